// *** inc/qnpei_pkg.sv ***
// Constants shared by the nibble port unit
package qnpei_pkg;
  // Port widths
  localparam int NIB_W = 4;
  localparam int P8_W = 2;
  localparam int KR_W = 8;
  // Synchroniser vector layout
  localparam int SYNC_W = 36;
  localparam int SY_P0 = 0;
  localparam int SY_P1 = 4;
  localparam int SY_P2 = 8;
  localparam int SY_P3 = 12;
  localparam int SY_P4 = 16;
  localparam int SY_P5 = 20;
  localparam int SY_P6 = 24;
  localparam int SY_P7 = 28;
  localparam int SY_P8 = 32;
  localparam int SY_XT1 = 34;
  localparam int SY_RSTN = 35;
  // Edge history layout
  localparam int EH_W = 12;
  localparam int EH_EXT_IRQ_BOTH_EDGE = 0;
  localparam int EH_EXT_IRQ_ZERO = 1;
  localparam int EH_EXT_IRQ_ONE = 2;
  localparam int EH_EXT_TEST_TWO = 3;
  localparam int EH_KR = 4;
  // Edge select encoding for the selectable interrupt
  localparam logic EDGE_RISE = 1'h0;
  localparam logic EDGE_FALL = 1'h1;
  // Reset values: pin not driven, no pull-up, output data high
  localparam logic OE_OFF_N = 1'h1;
  localparam logic PU_RST = 1'h0;
  localparam logic DATA_RST = 1'h1;
  // Open-drain pins only ever pull low
  localparam logic OD_LOW = 1'h0;
  // Noise filter settle time and its cycle count at 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  localparam int NOISE_FILT_NS = 20;
  localparam int NOISE_FILT_CYC = (NOISE_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_CNT_W = 4;
  localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(NOISE_FILT_CYC - 1);
endpackage

// *** hw/qnpei_port.sv ***
// Nibble port pin unit with edge detection on interrupt, key and test inputs
`timescale 1ns/1ps

module qnpei_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages; the first is read by the second only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end
  assign syncOut = sync_ff;
endmodule

module qnpei_port
  import qnpei_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic resetPinN,
  // Pin inputs
  input wire logic [NIB_W-1:0] inputPortZeroIn,
  input wire logic [NIB_W-1:0] inputPortOneIn,
  input wire logic [NIB_W-1:0] ioPortTwoIn,
  input wire logic [NIB_W-1:0] progIoPortThreeIn,
  input wire logic [NIB_W-1:0] opendrainPortFourIn,
  input wire logic [NIB_W-1:0] opendrainPortFiveIn,
  input wire logic [NIB_W-1:0] progIoPortSixIn,
  input wire logic [NIB_W-1:0] ioPortSevenIn,
  input wire logic [P8_W-1:0] ioPortEightIn,
  input wire logic subOscIn,
  // Pin outputs and active-low enables
  output logic [NIB_W-1:0] inputPortZeroOut,
  output logic [NIB_W-1:0] inputPortZeroOeN,
  output logic [NIB_W-1:0] ioPortTwoOut,
  output logic [NIB_W-1:0] ioPortTwoOeN,
  output logic [NIB_W-1:0] progIoPortThreeOut,
  output logic [NIB_W-1:0] progIoPortThreeOeN,
  output logic [NIB_W-1:0] opendrainPortFourOut,
  output logic [NIB_W-1:0] opendrainPortFourOeN,
  output logic [NIB_W-1:0] opendrainPortFiveOut,
  output logic [NIB_W-1:0] opendrainPortFiveOeN,
  output logic [NIB_W-1:0] progIoPortSixOut,
  output logic [NIB_W-1:0] progIoPortSixOeN,
  output logic [NIB_W-1:0] ioPortSevenOut,
  output logic [NIB_W-1:0] ioPortSevenOeN,
  output logic [P8_W-1:0] ioPortEightOut,
  output logic [P8_W-1:0] ioPortEightOeN,
  // Pull-up enables, one per group
  output logic [8:0] pullUpEn,
  // Core control
  input wire logic [8:0] pullUpSel,
  input wire logic [NIB_W-1:0] portTwoLatch,
  input wire logic portTwoOutMode,
  input wire logic [NIB_W-1:0] portTwoAltSel,
  input wire logic [NIB_W-1:0] portThreeLatch,
  input wire logic [NIB_W-1:0] portThreeDir,
  input wire logic [NIB_W-1:0] portFourLatch,
  input wire logic portFourOutMode,
  input wire logic [NIB_W-1:0] portFiveLatch,
  input wire logic portFiveOutMode,
  input wire logic [NIB_W-1:0] portSixLatch,
  input wire logic [NIB_W-1:0] portSixDir,
  input wire logic [NIB_W-1:0] portSevenLatch,
  input wire logic portSevenOutMode,
  input wire logic [P8_W-1:0] portEightLatch,
  input wire logic portEightOutMode,
  input wire logic extIrqZeroEdge,
  input wire logic extIrqZeroFiltEn,
  // Alternate functions from timers, clock, buzzer, serial
  input wire logic timerOutZero,
  input wire logic timerOutOne,
  input wire logic progClockOut,
  input wire logic buzzerOut,
  input wire logic serialClkOut,
  input wire logic serialClkDrive,
  input wire logic serialOutBus0,
  input wire logic serialOutBus0Drive,
  input wire logic serialInBus1Out,
  input wire logic serialInBus1Drive,
  // PROM write/verify
  input wire logic promMode,
  input wire logic [7:0] promDataOut,
  input wire logic promDataDrive,
  output logic [3:0] progModeSelect,
  output logic [7:0] progDataBus,
  // Synchronised reads to the core
  output logic [NIB_W-1:0] portZeroRd,
  output logic [NIB_W-1:0] portOneRd,
  output logic [NIB_W-1:0] portTwoRd,
  output logic [NIB_W-1:0] portThreeRd,
  output logic [NIB_W-1:0] portFourRd,
  output logic [NIB_W-1:0] portFiveRd,
  output logic [NIB_W-1:0] portSixRd,
  output logic [NIB_W-1:0] portSevenRd,
  output logic [P8_W-1:0] portEightRd,
  output logic timerEventIn,
  output logic subOscTest,
  // Events and flags
  output logic extIrqBothEdgeReq,
  output logic extIrqZeroReq,
  output logic extIrqOneReq,
  output logic extTestTwoFlag,
  input wire logic extTestTwoClr,
  output logic [KR_W-1:0] keyReturnFlag,
  input wire logic [KR_W-1:0] keyReturnClr
);
  logic [SYNC_W-1:0] pinSync;
  logic portRst, int0Raw, int0Src, int0Hit;
  logic [KR_W-1:0] krNow;
  logic [EH_W-1:0] edgeNow, edgeRise, edgeFall;
  logic [FILT_CNT_W-1:0] nxt_filtCnt, filtCnt_ff;
  logic filtVal_ff;
  logic [EH_W-1:0] edgeHist_ff;
  logic edgeValid_ff, irq4_ff, irq0_ff, irq1_ff, test2_ff;
  logic [KR_W-1:0] kr_ff;
  logic [NIB_W-1:0] alt2, nxt_p0Out, nxt_p0OeN, nxt_p2Out, nxt_p4OeN, nxt_p5OeN;
  logic [NIB_W-1:0] p0Out_ff, p0OeN_ff, p2Out_ff, p2OeN_ff, p3Out_ff, p3OeN_ff;
  logic [NIB_W-1:0] p4OeN_ff, p5OeN_ff, p6Out_ff, p6OeN_ff, p7Out_ff, p7OeN_ff;
  logic [P8_W-1:0] p8Out_ff, p8OeN_ff;
  logic [8:0] pullUp_ff;

  // Every pin, the sub oscillator and the reset pin cross into the core clock
  qnpei_sync #(.W(SYNC_W)) uPinSync (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn({resetPinN, subOscIn, ioPortEightIn, ioPortSevenIn, progIoPortSixIn, opendrainPortFiveIn,
              opendrainPortFourIn, progIoPortThreeIn, ioPortTwoIn, inputPortOneIn, inputPortZeroIn}),
    .syncOut(pinSync)
  );

  // Reset pin low, or the core reset, puts all ports back to reset state
  assign portRst = srst | ~pinSync[SY_RSTN];

  // Read paths
  assign portZeroRd = pinSync[SY_P0 +: NIB_W];
  assign portOneRd = pinSync[SY_P1 +: NIB_W];
  assign portTwoRd = pinSync[SY_P2 +: NIB_W];
  assign portThreeRd = pinSync[SY_P3 +: NIB_W];
  assign portFourRd = pinSync[SY_P4 +: NIB_W];
  assign portFiveRd = pinSync[SY_P5 +: NIB_W];
  assign portSixRd = pinSync[SY_P6 +: NIB_W];
  assign portSevenRd = pinSync[SY_P7 +: NIB_W];
  assign portEightRd = pinSync[SY_P8 +: P8_W];
  assign timerEventIn = pinSync[SY_P1 + 3];
  assign subOscTest = pinSync[SY_XT1];
  assign progModeSelect = pinSync[SY_P3 +: NIB_W];
  assign progDataBus = {pinSync[SY_P5 +: NIB_W], pinSync[SY_P4 +: NIB_W]};

  // Noise filter: new level accepted only after it held for the settle time
  assign int0Raw = pinSync[SY_P1];
  assign nxt_filtCnt = (int0Raw == filtVal_ff) ? '0 : filtCnt_ff + FILT_CNT_W'(1);
  always_ff @(posedge core_clk) begin
    if (portRst) begin
      filtCnt_ff <= '0;
      filtVal_ff <= 1'h0;
    end else begin
      filtCnt_ff <= (filtCnt_ff == FILT_LAST) ? '0 : nxt_filtCnt;
      filtVal_ff <= (int0Raw != filtVal_ff && filtCnt_ff == FILT_LAST) ? int0Raw : filtVal_ff;
    end
  end
  assign int0Src = extIrqZeroFiltEn ? filtVal_ff : int0Raw;

  // Edge detection compares the synchronised sample with the one before
  assign krNow = {pinSync[SY_P7 +: NIB_W], pinSync[SY_P6 +: NIB_W]};
  assign edgeNow = {krNow, pinSync[SY_P1 + 2], pinSync[SY_P1 + 1], int0Src, pinSync[SY_P0]};
  assign edgeRise = edgeValid_ff ? (edgeNow & ~edgeHist_ff) : '0;
  assign edgeFall = edgeValid_ff ? (~edgeNow & edgeHist_ff) : '0;
  assign int0Hit = (extIrqZeroEdge == EDGE_FALL) ? edgeFall[EH_EXT_IRQ_ZERO] : edgeRise[EH_EXT_IRQ_ZERO];

  // History is held invalid for a cycle after reset so no false edge fires
  always_ff @(posedge core_clk) begin
    if (portRst) begin
      edgeHist_ff <= '0;
      edgeValid_ff <= 1'h0;
    end else begin
      edgeHist_ff <= edgeNow;
      edgeValid_ff <= 1'h1;
    end
  end

  // Vectored requests are one-cycle pulses; test flags are sticky, set beats clear
  always_ff @(posedge core_clk) begin
    if (portRst) begin
      irq4_ff <= 1'h0;
      irq0_ff <= 1'h0;
      irq1_ff <= 1'h0;
      test2_ff <= 1'h0;
      kr_ff <= '0;
    end else begin
      irq4_ff <= edgeRise[EH_EXT_IRQ_BOTH_EDGE] | edgeFall[EH_EXT_IRQ_BOTH_EDGE];
      irq0_ff <= int0Hit;
      irq1_ff <= edgeRise[EH_EXT_IRQ_ONE];
      test2_ff <= edgeRise[EH_EXT_TEST_TWO] | (test2_ff & ~extTestTwoClr);
      kr_ff <= edgeFall[EH_KR +: KR_W] | (kr_ff & ~keyReturnClr);
    end
  end
  assign extIrqBothEdgeReq = irq4_ff;
  assign extIrqZeroReq = irq0_ff;
  assign extIrqOneReq = irq1_ff;
  assign extTestTwoFlag = test2_ff;
  assign keyReturnFlag = kr_ff;

  // Port zero: bit 0 input only, upper bits driven when serial claims them
  assign nxt_p0Out = {serialInBus1Out, serialOutBus0, serialClkOut, 1'h0};
  assign nxt_p0OeN = {~serialInBus1Drive, ~serialOutBus0Drive, ~serialClkDrive, OE_OFF_N};
  // Port two alternate outputs override the latch per selected bit
  assign alt2 = {buzzerOut, progClockOut, timerOutOne, timerOutZero};
  assign nxt_p2Out = (portTwoAltSel & alt2) | (~portTwoAltSel & portTwoLatch);
  // Open drain: enable only to pull low; PROM verify drives the data bus
  assign nxt_p4OeN = promMode ? ~({NIB_W{promDataDrive}} & ~promDataOut[3:0])
                              : ~({NIB_W{portFourOutMode}} & ~portFourLatch);
  assign nxt_p5OeN = promMode ? ~({NIB_W{promDataDrive}} & ~promDataOut[7:4])
                              : ~({NIB_W{portFiveOutMode}} & ~portFiveLatch);

  // Pin drive registers; reset leaves every pin undriven and pull-ups off
  always_ff @(posedge core_clk) begin
    if (portRst) begin
      p0Out_ff <= {NIB_W{DATA_RST}};
      p0OeN_ff <= {NIB_W{OE_OFF_N}};
      p2Out_ff <= {NIB_W{DATA_RST}};
      p2OeN_ff <= {NIB_W{OE_OFF_N}};
      p3Out_ff <= {NIB_W{DATA_RST}};
      p3OeN_ff <= {NIB_W{OE_OFF_N}};
      p4OeN_ff <= {NIB_W{OE_OFF_N}};
      p5OeN_ff <= {NIB_W{OE_OFF_N}};
      p6Out_ff <= {NIB_W{DATA_RST}};
      p6OeN_ff <= {NIB_W{OE_OFF_N}};
      p7Out_ff <= {NIB_W{DATA_RST}};
      p7OeN_ff <= {NIB_W{OE_OFF_N}};
      p8Out_ff <= {P8_W{DATA_RST}};
      p8OeN_ff <= {P8_W{OE_OFF_N}};
      pullUp_ff <= {9{PU_RST}};
    end else begin
      p0Out_ff <= nxt_p0Out;
      p0OeN_ff <= nxt_p0OeN;
      p2Out_ff <= nxt_p2Out;
      p2OeN_ff <= {NIB_W{~portTwoOutMode}};
      p3Out_ff <= portThreeLatch;
      p3OeN_ff <= promMode ? {NIB_W{OE_OFF_N}} : ~portThreeDir;
      p4OeN_ff <= nxt_p4OeN;
      p5OeN_ff <= nxt_p5OeN;
      p6Out_ff <= portSixLatch;
      p6OeN_ff <= ~portSixDir;
      p7Out_ff <= portSevenLatch;
      p7OeN_ff <= {NIB_W{~portSevenOutMode}};
      p8Out_ff <= portEightLatch;
      p8OeN_ff <= {P8_W{~portEightOutMode}};
      pullUp_ff <= pullUpSel;
    end
  end

  // Pin outputs; open-drain data is always low
  assign inputPortZeroOut = p0Out_ff;
  assign inputPortZeroOeN = p0OeN_ff;
  assign ioPortTwoOut = p2Out_ff;
  assign ioPortTwoOeN = p2OeN_ff;
  assign progIoPortThreeOut = p3Out_ff;
  assign progIoPortThreeOeN = p3OeN_ff;
  assign opendrainPortFourOut = {NIB_W{OD_LOW}};
  assign opendrainPortFourOeN = p4OeN_ff;
  assign opendrainPortFiveOut = {NIB_W{OD_LOW}};
  assign opendrainPortFiveOeN = p5OeN_ff;
  assign progIoPortSixOut = p6Out_ff;
  assign progIoPortSixOeN = p6OeN_ff;
  assign ioPortSevenOut = p7Out_ff;
  assign ioPortSevenOeN = p7OeN_ff;
  assign ioPortEightOut = p8Out_ff;
  assign ioPortEightOeN = p8OeN_ff;
  // Ports four and five have no pull-up, so slots 4 and 5 stay off; slot 8 serves port eight
  assign pullUpEn = {pullUp_ff[8:6], 2'h0, pullUp_ff[3:0]};

  // Checks
  both_edge_pulse_a: assert property (@(posedge core_clk) disable iff (portRst)
    edgeValid_ff && (pinSync[SY_P0] != edgeHist_ff[EH_EXT_IRQ_BOTH_EDGE]) |=> extIrqBothEdgeReq)
    else $error("both-edge input missed an edge");
  irq_zero_edge_a: assert property (@(posedge core_clk) disable iff (portRst)
    extIrqZeroReq |-> (($past(extIrqZeroEdge) == EDGE_FALL) ? ($past(int0Src, 2) && !$past(int0Src))
                                                            : (!$past(int0Src, 2) && $past(int0Src))))
    else $error("interrupt zero fired on wrong edge");
  test_two_set_a: assert property (@(posedge core_clk) disable iff (portRst)
    edgeRise[EH_EXT_TEST_TWO] |=> extTestTwoFlag)
    else $error("test flag not set by rising edge");
  test_two_hold_a: assert property (@(posedge core_clk) disable iff (portRst)
    extTestTwoFlag && !extTestTwoClr |=> extTestTwoFlag)
    else $error("test flag dropped without clear");
  key_fall_flag_a: assert property (@(posedge core_clk) disable iff (portRst)
    edgeValid_ff && !krNow[0] && edgeHist_ff[EH_KR] |=> keyReturnFlag[0])
    else $error("key return falling edge lost");
  reset_undriven_a: assert property (@(posedge core_clk)
    portRst |=> (&ioPortTwoOeN) && (&opendrainPortFourOeN) && (&progIoPortSixOeN) && (&ioPortEightOeN))
    else $error("pin driven after reset");
  prom_md_input_a: assert property (@(posedge core_clk) disable iff (portRst)
    promMode |=> &progIoPortThreeOeN)
    else $error("mode select pins driven in PROM mode");
  od_no_high_a: assert property (@(posedge core_clk) disable iff (portRst)
    !promMode && portFourOutMode && portFourLatch[0] |=> opendrainPortFourOeN[0])
    else $error("open drain pin pulled low for a one");
  dir_per_bit_a: assert property (@(posedge core_clk) disable iff (portRst)
    !promMode |=> progIoPortThreeOeN == ~$past(portThreeDir))
    else $error("port three direction not per bit");
  filt_settle_a: assert property (@(posedge core_clk) disable iff (portRst)
    $changed(filtVal_ff) |-> $past(filtCnt_ff) == FILT_LAST)
    else $error("filter changed before settle time");
endmodule

// *** dv/qnpei_board.sv ***
// Board-side pin model: keys, sources, programmer and pull resistors
`timescale 1ns/1ps

module qnpei_board #(
  parameter int W = 24
) (
  // Clock
  input wire logic core_clk,
  // Device pin drive
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOeN,
  input wire logic [W-1:0] pullUp,
  // Board sources
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extEn,
  // Resolved pin levels
  output logic [W-1:0] pin
);
  logic [W-1:0] last_ff;

  // Remember last level for floating pins
  always_ff @(posedge core_clk) begin
    last_ff <= pin;
  end

  // Device drive wins; a floating pin with no pull-up keeps toggling so it never looks stable
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pinOeN[i]) begin
        pin[i] = pinOut[i];
      end else if (extEn[i]) begin
        pin[i] = extVal[i];
      end else if (pullUp[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = ~last_ff[i];
      end
    end
  end
endmodule

// *** dv/quad_nibble_port_edge_inputs_tb.sv ***
// Self-checking bench for the nibble port pin unit
`timescale 1ns/1ps

module quad_nibble_port_edge_inputs_tb
  import qnpei_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic resetPinN = 1'b1;
  logic [3:0] inputPortZeroIn, inputPortOneIn, portTwoLatch, portTwoAltSel, portThreeLatch, portThreeDir;
  logic [3:0] portFourLatch, portFiveLatch, portSixLatch, portSixDir, portSevenLatch;
  wire [3:0] ioPortTwoIn, progIoPortThreeIn, opendrainPortFourIn, opendrainPortFiveIn, progIoPortSixIn, ioPortSevenIn;
  logic [3:0] inputPortZeroOut, inputPortZeroOeN, ioPortTwoOut, ioPortTwoOeN, progIoPortThreeOut, progIoPortThreeOeN;
  logic [3:0] opendrainPortFourOut, opendrainPortFourOeN, opendrainPortFiveOut, opendrainPortFiveOeN;
  logic [3:0] progIoPortSixOut, progIoPortSixOeN, ioPortSevenOut, ioPortSevenOeN, progModeSelect;
  logic [3:0] portZeroRd, portOneRd, portTwoRd, portThreeRd, portFourRd, portFiveRd, portSixRd, portSevenRd;
  logic [1:0] portEightLatch, ioPortEightOut, ioPortEightOeN, portEightRd;
  wire [1:0] ioPortEightIn;
  logic [7:0] promDataOut, keyReturnClr, progDataBus, keyReturnFlag;
  logic [8:0] pullUpSel, pullUpEn;
  logic subOscIn, portTwoOutMode, portFourOutMode, portFiveOutMode, portSevenOutMode, portEightOutMode;
  logic extIrqZeroEdge, extIrqZeroFiltEn, timerOutZero, timerOutOne, progClockOut, buzzerOut;
  logic serialClkOut, serialClkDrive, serialOutBus0, serialOutBus0Drive, serialInBus1Out, serialInBus1Drive;
  logic promMode, promDataDrive, extTestTwoClr, timerEventIn, subOscTest;
  logic extIrqBothEdgeReq, extIrqZeroReq, extIrqOneReq, extTestTwoFlag;
  logic [25:0] extVal = 26'h3FFFFFF;
  logic [25:0] extEn = 26'h3FFFFFF;
  int fails = 0;
  int compares = 0;
  int nBoth = 0;
  int nZero = 0;
  int nOne = 0;

  always #2.5 core_clk = ~core_clk;

  qnpei_port dut (.*);

  // Board on ports two to eight, packed {8,7,6,5,4,3,2}
  qnpei_board #(.W(26)) board (.core_clk(core_clk),
    .pinOut({ioPortEightOut, ioPortSevenOut, progIoPortSixOut, opendrainPortFiveOut, opendrainPortFourOut,
             progIoPortThreeOut, ioPortTwoOut}),
    .pinOeN({ioPortEightOeN, ioPortSevenOeN, progIoPortSixOeN, opendrainPortFiveOeN, opendrainPortFourOeN,
             progIoPortThreeOeN, ioPortTwoOeN}),
    .pullUp({{2{pullUpEn[8]}}, {4{pullUpEn[7]}}, {4{pullUpEn[6]}}, {4{pullUpEn[5]}}, {4{pullUpEn[4]}},
             {4{pullUpEn[3]}}, {4{pullUpEn[2]}}}),
    .extVal(extVal), .extEn(extEn),
    .pin({ioPortEightIn, ioPortSevenIn, progIoPortSixIn, opendrainPortFiveIn, opendrainPortFourIn, progIoPortThreeIn,
          ioPortTwoIn}));

  // Count one-cycle request pulses
  always @(posedge core_clk) begin
    if (extIrqBothEdgeReq === 1'b1) nBoth++;
    if (extIrqZeroReq === 1'b1) nZero++;
    if (extIrqOneReq === 1'b1) nOne++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reset state with pull-ups requested: must stay off
  task automatic resetState();
    chk(32'({inputPortZeroOeN, ioPortTwoOeN, progIoPortThreeOeN, opendrainPortFourOeN, opendrainPortFiveOeN,
             progIoPortSixOeN, ioPortSevenOeN, ioPortEightOeN}), 32'h3FFFFFFF);
    chk(32'(pullUpEn), 32'h0);
    chk(32'({opendrainPortFiveOut, opendrainPortFourOut}), 32'h0);
    chk(32'({keyReturnFlag, extTestTwoFlag}), 32'h0);
  endtask

  // All eight key lines fall, then rise after clear
  task automatic keyScan();
    extVal[23:16] = 8'h00;
    step(1);
    chk(32'(keyReturnFlag), 32'h0);
    step(5);
    chk(32'(keyReturnFlag), 32'hFF);
    keyReturnClr = 8'hFF;
    step(1);
    keyReturnClr = 8'h00;
    extVal[23:16] = 8'hFF;
    step(6);
    chk(32'(keyReturnFlag), 32'h0);
  endtask

  // Both-edge, selectable and rising interrupts plus the test input
  task automatic irqEdges();
    nBoth = 0; nZero = 0; nOne = 0;
    extIrqZeroEdge = EDGE_FALL;
    inputPortZeroIn[0] = 1'b1;
    inputPortOneIn[2:0] = 3'h7;
    step(8);
    chk(32'(nBoth), 32'h1);
    chk(32'(nZero), 32'h0);
    chk(32'(nOne), 32'h1);
    chk(32'(extTestTwoFlag), 32'h1);
    extTestTwoClr = 1'b1;
    step(1);
    extTestTwoClr = 1'b0;
    inputPortZeroIn[0] = 1'b0;
    inputPortOneIn[2:0] = 3'h0;
    step(8);
    chk(32'(nBoth), 32'h2);
    chk(32'(nZero), 32'h1);
    chk(32'(extTestTwoFlag), 32'h0);
    // Filtered rising edge: short glitch dropped, steady level taken once
    extIrqZeroEdge = EDGE_RISE;
    extIrqZeroFiltEn = 1'b1;
    inputPortOneIn[0] = 1'b1;
    step(2);
    inputPortOneIn[0] = 1'b0;
    step(10);
    chk(32'(nZero), 32'h1);
    inputPortOneIn[0] = 1'b1;
    step(12);
    chk(32'(nZero), 32'h2);
  endtask

  // Timer event and sub-oscillator test reads
  task automatic pinReads();
    inputPortOneIn[3] = 1'b1;
    subOscIn = 1'b1;
    step(4);
    chk(32'({timerEventIn, subOscTest}), 32'h3);
  endtask

  // Directions, alternate outputs, open drain and pull-up groups
  task automatic outputs();
    pullUpSel = 9'h1FF;
    portTwoOutMode = 1'b1; portTwoAltSel = 4'hF; portTwoLatch = 4'hA;
    timerOutZero = 1'b1; timerOutOne = 1'b0; progClockOut = 1'b1; buzzerOut = 1'b1;
    portThreeDir = 4'h5; portThreeLatch = 4'hF; portSixDir = 4'hC; portSixLatch = 4'h4;
    portFourOutMode = 1'b1; portFourLatch = 4'h6; portFiveOutMode = 1'b1; portFiveLatch = 4'h9;
    portSevenOutMode = 1'b1; portSevenLatch = 4'h7; portEightOutMode = 1'b1; portEightLatch = 2'h2;
    serialClkDrive = 1'b1; serialClkOut = 1'b0; serialOutBus0Drive = 1'b1; serialOutBus0 = 1'b1;
    step(2);
    chk(32'(pullUpEn), 32'h1CF);
    chk(32'({ioPortTwoOeN, ioPortTwoOut}), 32'h0D);
    chk(32'({progIoPortThreeOeN, progIoPortThreeOut & 4'h5}), 32'hA5);
    chk(32'({progIoPortSixOeN, progIoPortSixOut & 4'hC}), 32'h34);
    chk(32'({opendrainPortFourOeN, opendrainPortFiveOeN, opendrainPortFourOut}), 32'h690);
    chk(32'({ioPortSevenOeN, ioPortSevenOut, ioPortEightOeN, ioPortEightOut}), 32'h072);
    chk(32'({inputPortZeroOeN, inputPortZeroOut[2:1]}), 32'h26);
    step(3);
    chk(32'({portSevenRd, portEightRd}), 32'h1E);
  endtask

  // Reset pin drops every port back to input
  task automatic pinReset();
    resetPinN = 1'b0;
    step(5);
    chk(32'({ioPortTwoOeN, progIoPortThreeOeN, opendrainPortFourOeN, ioPortSevenOeN}), 32'hFFFF);
    chk(32'(pullUpEn), 32'h0);
    resetPinN = 1'b1;
    step(6);
    chk(32'(ioPortTwoOeN), 32'h0);
  endtask

  // Programmer drives mode select and data bus while port three wants to output
  task automatic promAccess();
    portThreeDir = 4'hF;
    portFourOutMode = 1'b0; portFiveOutMode = 1'b0;
    extVal[15:4] = 12'hC39;
    promMode = 1'b1;
    step(5);
    chk(32'(progIoPortThreeOeN), 32'hF);
    chk(32'({progModeSelect, progDataBus}), 32'h9C3);
    // Verify drive: zeros of the data byte pull the open-drain pins low
    promDataOut = 8'h5A;
    promDataDrive = 1'b1;
    step(2);
    chk(32'({opendrainPortFiveOeN, opendrainPortFourOeN}), 32'h5A);
  endtask

  initial begin
    {inputPortZeroIn, inputPortOneIn, portTwoLatch, portTwoAltSel, portThreeLatch, portThreeDir, portFourLatch,
     portFiveLatch, portSixLatch, portSixDir, portSevenLatch, portEightLatch, promDataOut,
     keyReturnClr, subOscIn, portTwoOutMode, portFourOutMode, portFiveOutMode, portSevenOutMode, portEightOutMode,
     extIrqZeroEdge, extIrqZeroFiltEn, timerOutZero, timerOutOne, progClockOut, buzzerOut, serialClkOut,
     serialClkDrive, serialOutBus0, serialOutBus0Drive, serialInBus1Out, serialInBus1Drive, promMode,
     promDataDrive, extTestTwoClr} = '0;
    pullUpSel = 9'h1FF;
    step(6);
    resetState();
    step(2);
    srst = 1'b0;
    pullUpSel = 9'h000;
    step(6);
    keyScan();
    irqEdges();
    pinReads();
    outputs();
    pinReset();
    promAccess();
    results();
  end

  // Hang guard
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule
